// >>> core/vfm_map.svh
// Register indices, field positions and reset values of the sequencer font and plane mapping block
`ifndef VFM_MAP_SVH
`define VFM_MAP_SVH
`define VFM_IO_INDEX      16'h03C4
`define VFM_IO_DATA       16'h03C5
`define VFM_IDX_RESET     3'h0
`define VFM_IDX_CLOCKING  3'h1
`define VFM_IDX_PLANEMASK 3'h2
`define VFM_IDX_FONTSEL   3'h3
`define VFM_IDX_MEMMODE   3'h4
`define VFM_FS_A_HI       5
`define VFM_FS_B_HI       4
`define VFM_FS_A_LO1      3
`define VFM_FS_A_LO0      2
`define VFM_FS_B_LO1      1
`define VFM_FS_B_LO0      0
`define VFM_MM_CHAIN4     3
`define VFM_MM_ODDEVEN    2
`define VFM_MM_EXTMEM     1
`define VFM_RST_RESET     8'h03
`define VFM_RST_CLOCKING  8'h00
`define VFM_RST_PLANEMASK 8'h0F
`define VFM_RST_FONTSEL   8'h00
`define VFM_RST_MEMMODE   8'h00
`define VFM_MASK_RESET    8'h03
`define VFM_MASK_CLOCKING 8'h3D
`define VFM_MASK_PLANEMASK 8'h0F
`define VFM_MASK_FONTSEL  8'h3F
`define VFM_MASK_MEMMODE  8'h0E
`define VFM_SMALL_ADDR_BITS 16
`define VFM_SMALL_MASK    18'h0FFFF
`define VFM_RST_INDEX     3'h0
`define VFM_ATTR_FONT_SW  3
`define VFM_PLANES_EVEN   4'h5
`define VFM_PLANES_ODD    4'hA
`endif

// >>> core/vfm_pkg.sv
// Types shared by the sequencer font and plane mapping block
package vfm_pkg;
  typedef logic [2:0] vfm_fontsel_t;
  typedef logic [3:0] vfm_planes_t;
  typedef enum logic [1:0] {
    VFM_MAP_SEQ    = 2'h0,
    VFM_MAP_ODDEV  = 2'h1,
    VFM_MAP_CHAIN4 = 2'h3
  } vfm_mapmode_t;
endpackage : vfm_pkg

// >>> core/vfm_cfg_if.sv
// Configuration bundle passed from the register file to the plane mapper
`timescale 1ns/100ps
`default_nettype none
interface vfm_cfg_if;
  logic                 chainFour;
  logic                 oddEvenOff;
  logic                 extendedMemoryEnable;
  vfm_pkg::vfm_planes_t planeMask;
  modport regs (output chainFour, output oddEvenOff, output extendedMemoryEnable, output planeMask);
  modport mapper (input chainFour, input oddEvenOff, input extendedMemoryEnable, input planeMask);
endinterface : vfm_cfg_if
`default_nettype wire

// >>> core/vfm_plane_mapper.sv
// Combinational mapping of a system address to plane enables and plane offset
`timescale 1ns/100ps
`default_nettype none
`include "vfm_map.svh"
module vfm_plane_mapper #(
  parameter int ADDR_W = 18
) (
  vfm_cfg_if.mapper                 cfg,
  input  wire logic [ADDR_W-1:0]    sysAddr,
  output logic [3:0]                planeSel,
  output logic [ADDR_W-1:0]         planeOffset,
  output logic                      addrInRange
);
  vfm_pkg::vfm_mapmode_t mode;
  always_comb begin
    if (cfg.chainFour)
      mode = vfm_pkg::VFM_MAP_CHAIN4;
    else if (!cfg.oddEvenOff)
      mode = vfm_pkg::VFM_MAP_ODDEV;
    else
      mode = vfm_pkg::VFM_MAP_SEQ;
  end
  always_comb begin
    planeSel    = 4'h0;
    planeOffset = sysAddr;
    case (mode)
      vfm_pkg::VFM_MAP_CHAIN4: begin
        planeSel    = 4'h1 << sysAddr[1:0];
        planeOffset = {2'b00, sysAddr[ADDR_W-1:2]};
      end
      vfm_pkg::VFM_MAP_ODDEV: begin
        // Map mask still gates the pair, hence the AND
        planeSel    = (sysAddr[0] ? `VFM_PLANES_ODD : `VFM_PLANES_EVEN) & cfg.planeMask;
        planeOffset = sysAddr;
      end
      vfm_pkg::VFM_MAP_SEQ: begin
        planeSel    = cfg.planeMask;
        planeOffset = sysAddr;
      end
      default: begin
        planeSel    = 4'h0;
        planeOffset = sysAddr;
      end
    endcase
  end
  // Without extended memory only the low 64KB answers
  assign addrInRange = cfg.extendedMemoryEnable | ((sysAddr & ADDR_W'(`VFM_SMALL_MASK)) == sysAddr);
endmodule : vfm_plane_mapper
`default_nettype wire

// >>> core/vfm_sequencer.sv
// Sequencer register file with font table selection and plane mapping
`timescale 1ns/100ps
`default_nettype none
`include "vfm_map.svh"
module vfm_sequencer #(
  parameter int ADDR_W = 18
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic [15:0]       ioAddr,
  input  wire logic [7:0]        ioWrData,
  input  wire logic              ioWr,
  input  wire logic              ioRd,
  output logic [7:0]             ioRdData,
  output logic                   ioRdValid,
  input  wire logic              alphaMode,
  input  wire logic [7:0]        attrByte,
  input  wire logic [7:0]        charCode,
  input  wire logic [4:0]        glyphRow,
  output logic [15:0]            fontAddr,
  input  wire logic [ADDR_W-1:0] sysAddr,
  input  wire logic              sysReq,
  output logic [3:0]             planeEnable,
  output logic [ADDR_W-1:0]      planeAddr,
  output logic                   sysHit,
  output logic                   dualFontActive
);
  // ==========================================================
  // Register file
  logic [2:0] sequencer_index;
  logic [7:0] resetCtl;
  logic [7:0] clockingMode;
  logic [7:0] planeWriteMask;
  logic [7:0] font_table_select;
  logic [7:0] plane_addressing_mode;

  function automatic logic [7:0] vfm_read(input logic [2:0] idx, input logic [7:0] rr, input logic [7:0] cm,
                                          input logic [7:0] pm, input logic [7:0] fs, input logic [7:0] mm);
    case (idx)
      `VFM_IDX_RESET:     vfm_read = rr;
      `VFM_IDX_CLOCKING:  vfm_read = cm;
      `VFM_IDX_PLANEMASK: vfm_read = pm;
      `VFM_IDX_FONTSEL:   vfm_read = fs;
      `VFM_IDX_MEMMODE:   vfm_read = mm;
      default:            vfm_read = 8'h00;
    endcase
  endfunction : vfm_read

  wire logic dataWr = ioWr && (ioAddr == `VFM_IO_DATA);

  always_ff @(posedge mclk) begin
    if (!rst_b)
      sequencer_index <= `VFM_RST_INDEX;
    else if (ioWr && ioAddr == `VFM_IO_INDEX)
      sequencer_index <= ioWrData[2:0];
  end

  // Unused bits are masked off on write, so reads return zero there
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      resetCtl              <= `VFM_RST_RESET;
      clockingMode          <= `VFM_RST_CLOCKING;
      planeWriteMask        <= `VFM_RST_PLANEMASK;
      font_table_select     <= `VFM_RST_FONTSEL;
      plane_addressing_mode <= `VFM_RST_MEMMODE;
    end else if (dataWr) begin
      case (sequencer_index)
        `VFM_IDX_RESET:     resetCtl              <= ioWrData & `VFM_MASK_RESET;
        `VFM_IDX_CLOCKING:  clockingMode          <= ioWrData & `VFM_MASK_CLOCKING;
        `VFM_IDX_PLANEMASK: planeWriteMask        <= ioWrData & `VFM_MASK_PLANEMASK;
        `VFM_IDX_FONTSEL:   font_table_select     <= ioWrData & `VFM_MASK_FONTSEL;
        `VFM_IDX_MEMMODE:   plane_addressing_mode <= ioWrData & `VFM_MASK_MEMMODE;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ioRdData  <= 8'h00;
      ioRdValid <= 1'b0;
    end else begin
      ioRdValid <= ioRd && (ioAddr == `VFM_IO_INDEX || ioAddr == `VFM_IO_DATA);
      if (ioRd && ioAddr == `VFM_IO_INDEX)
        ioRdData <= {5'h00, sequencer_index};
      else if (ioRd && ioAddr == `VFM_IO_DATA)
        ioRdData <= vfm_read(sequencer_index, resetCtl, clockingMode, planeWriteMask,
                             font_table_select, plane_addressing_mode);
      else
        ioRdData <= 8'h00;
    end
  end

  // ==========================================================
  // Font table selection
  vfm_pkg::vfm_fontsel_t fontASel;
  vfm_pkg::vfm_fontsel_t fontBSel;
  vfm_pkg::vfm_fontsel_t chosenSel;
  logic                  extendedMemoryEnable;
  logic                  dualOk;
  logic                  useFontA;
  assign fontASel = {font_table_select[`VFM_FS_A_HI], font_table_select[`VFM_FS_A_LO1],
                     font_table_select[`VFM_FS_A_LO0]};
  assign fontBSel = {font_table_select[`VFM_FS_B_HI], font_table_select[`VFM_FS_B_LO1],
                     font_table_select[`VFM_FS_B_LO0]};
  assign extendedMemoryEnable = plane_addressing_mode[`VFM_MM_EXTMEM];
  // Dual fonts rely on software enabling extended memory first
  assign dualOk    = alphaMode && extendedMemoryEnable && (fontASel != fontBSel);
  // With the feature off both selects fall back to table A's location alone
  assign useFontA  = dualOk ? attrByte[`VFM_ATTR_FONT_SW] : 1'b1;
  assign chosenSel = useFontA ? fontASel : fontBSel;

  // Region order interleaves: low two bits step by two regions, MSB picks odd one
  function automatic logic [2:0] vfm_region(input logic [2:0] sel);
    vfm_region = {sel[1:0], sel[2]};
  endfunction : vfm_region

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      fontAddr       <= 16'h0000;
      dualFontActive <= 1'b0;
    end else begin
      fontAddr       <= {vfm_region(chosenSel), charCode, glyphRow};
      dualFontActive <= dualOk;
    end
  end

  // ==========================================================
  // Plane mapping
  vfm_cfg_if cfg ();
  assign cfg.chainFour            = plane_addressing_mode[`VFM_MM_CHAIN4];
  assign cfg.oddEvenOff           = plane_addressing_mode[`VFM_MM_ODDEVEN];
  assign cfg.extendedMemoryEnable = extendedMemoryEnable;
  assign cfg.planeMask            = planeWriteMask[3:0];

  logic [3:0]        mapSel;
  logic [ADDR_W-1:0] mapOffset;
  logic              mapInRange;
  vfm_plane_mapper #(.ADDR_W(ADDR_W)) u_mapper (
    .cfg         (cfg.mapper),
    .sysAddr     (sysAddr),
    .planeSel    (mapSel),
    .planeOffset (mapOffset),
    .addrInRange (mapInRange)
  );

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      planeEnable <= 4'h0;
      planeAddr   <= '0;
      sysHit      <= 1'b0;
    end else begin
      sysHit      <= sysReq && mapInRange;
      planeEnable <= (sysReq && mapInRange) ? mapSel : 4'h0;
      planeAddr   <= mapOffset;
    end
  end
endmodule : vfm_sequencer
`default_nettype wire

// >>> verif/vfm_sequencer_chk.sv
// Port checker for the font and plane mapping sequencer
`timescale 1ns/100ps
`default_nettype none
`include "vfm_map.svh"
module vfm_sequencer_chk #(
  parameter int ADDR_W = 18
) (
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic [15:0]       ioAddr,
  input wire logic [7:0]        ioWrData,
  input wire logic              ioWr,
  input wire logic              ioRd,
  input wire logic              ioRdValid,
  input wire logic              alphaMode,
  input wire logic [7:0]        attrByte,
  input wire logic [7:0]        charCode,
  input wire logic [4:0]        glyphRow,
  input wire logic [15:0]       fontAddr,
  input wire logic [ADDR_W-1:0] sysAddr,
  input wire logic              sysReq,
  input wire logic [3:0]        planeEnable,
  input wire logic [ADDR_W-1:0] planeAddr,
  input wire logic              sysHit,
  input wire logic              dualFontActive
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ==========
  // Shadow of index and mode, needed to know which mapping applies
  logic [2:0] idx;
  logic [7:0] mode;
  logic [7:0] fsel;
  logic [7:0] pmask;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      idx <= 3'h0;
      mode <= `VFM_RST_MEMMODE;
      fsel <= `VFM_RST_FONTSEL;
      pmask <= `VFM_RST_PLANEMASK;
    end else if (ioWr && ioAddr == `VFM_IO_INDEX) begin
      idx <= ioWrData[2:0];
    end else if (ioWr && ioAddr == `VFM_IO_DATA) begin
      if (idx == `VFM_IDX_MEMMODE) mode <= ioWrData;
      if (idx == `VFM_IDX_FONTSEL) fsel <= ioWrData;
      if (idx == `VFM_IDX_PLANEMASK) pmask <= ioWrData;
    end
  end
  logic ioHit;
  assign ioHit = ioRd && (ioAddr == `VFM_IO_INDEX || ioAddr == `VFM_IO_DATA);
  a_read_answer: assert property (ioHit |=> ioRdValid)
    else $error("read not answered");
  a_stray_valid: assert property (!ioHit |=> !ioRdValid)
    else $error("read answer without read");
  a_font_layout: assert property (1'b1 |=> fontAddr[12:0] == {$past(charCode), $past(glyphRow)})
    else $error("font address layout wrong");
  a_dual_gate: assert property (!alphaMode || !mode[1] |=> !dualFontActive)
    else $error("dual font without enable");
  a_chain_map: assert property (sysReq && mode[3] && mode[1] |=> sysHit
    && planeEnable == 4'h1 << $past(sysAddr[1:0]) && planeAddr == $past(sysAddr) >> 2)
    else $error("chain mapping wrong");
  a_odd_even: assert property (sysReq && mode[3:1] == 3'h1 |=>
    planeEnable == (($past(sysAddr[0]) ? 4'hA : 4'h5) & $past(pmask[3:0])))
    else $error("odd even plane wrong");
  a_seq_mask: assert property (sysReq && mode[3:1] == 3'h3 |=> planeEnable == $past(pmask[3:0]))
    else $error("plane mask not applied");
  a_font_a_only: assert property (!alphaMode |=> fontAddr[15:13] == {$past(fsel[3:2]), $past(fsel[5])})
    else $error("font A region wrong");
  a_font_b_pick: assert property (alphaMode && mode[1] && !attrByte[3]
    && {fsel[5], fsel[3:2]} != {fsel[4], fsel[1:0]} |=> fontAddr[15:13] == {$past(fsel[1:0]), $past(fsel[4])})
    else $error("font B region wrong");
  a_seq_addr: assert property (sysReq && !mode[3] && mode[1] |=> planeAddr == $past(sysAddr))
    else $error("plane offset wrong");
  a_range_gate: assert property (sysReq && !mode[1] && sysAddr[ADDR_W-1:16] != '0 |=>
    !sysHit && planeEnable == 4'h0)
    else $error("access above small memory");
  a_idle_off: assert property (!sysReq |=> !sysHit && planeEnable == 4'h0)
    else $error("planes enabled while idle");
endmodule : vfm_sequencer_chk
bind vfm_sequencer vfm_sequencer_chk #(.ADDR_W(ADDR_W)) chk (.mclk, .rst_b, .ioAddr, .ioWrData, .ioWr, .ioRd, .ioRdValid,
  .alphaMode, .attrByte, .charCode, .glyphRow, .fontAddr, .sysAddr, .sysReq, .planeEnable, .planeAddr, .sysHit,
  .dualFontActive);
`default_nettype wire

// >>> verif/vfm_host_model.sv
// Host I/O bus model for the sequencer index and data ports
`timescale 1ns/100ps
`default_nettype none
module vfm_host_model (
  input  wire logic   mclk,
  output logic [15:0] ioAddr,
  output logic [7:0]  ioWrData,
  output logic        ioWr,
  output logic        ioRd
);
  initial begin
    {ioAddr, ioWrData, ioWr, ioRd} = '0;
  end
  // ==========
  // Released address and data lines show the inverse so a stale value never passes; the strobes drop to zero
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    ioAddr = a;
    ioWrData = d;
    ioWr = wr;
    ioRd = !wr;
    @(negedge mclk);
    ioAddr = ~a;
    ioWrData = ~d;
    ioWr = 1'b0;
    ioRd = 1'b0;
  endtask : xfer
endmodule : vfm_host_model
`default_nettype wire

// >>> verif/tb_vfm_sequencer.sv
// Self-checking bench for the font and plane mapping sequencer
`timescale 1ns/100ps
`default_nettype none
`include "vfm_map.svh"
module tb_vfm_sequencer;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] ioAddr, fontAddr;
  logic [7:0] ioWrData, ioRdData, attrByte, charCode, fs, mask;
  logic ioWr, ioRd, ioRdValid, alphaMode, sysReq, sysHit, dualFontActive;
  logic [4:0] glyphRow;
  logic [17:0] sysAddr, planeAddr, a;
  logic [3:0] planeEnable, pe;
  logic [2:0] selA, selB, sel;
  logic [7:0] expQ[$];
  logic [7:0] modes[5] = '{8'h0A, 8'h02, 8'h06, 8'h00, 8'h04};
  int failCount = 0;
  int samplesChecked = 0;
  always #25 mclk = ~mclk;
  vfm_host_model host (.mclk, .ioAddr, .ioWrData, .ioWr, .ioRd);
  vfm_sequencer #(.ADDR_W(18)) DUT (.mclk, .rst_b, .ioAddr, .ioWrData, .ioWr, .ioRd, .ioRdData, .ioRdValid,
    .alphaMode, .attrByte, .charCode, .glyphRow, .fontAddr, .sysAddr, .sysReq, .planeEnable, .planeAddr, .sysHit,
    .dualFontActive);
  // ==========
  // Shared tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wreg(input logic [7:0] i, input logic [7:0] v);
    host.xfer(1'b1, `VFM_IO_INDEX, i);
    host.xfer(1'b1, `VFM_IO_DATA, v);
  endtask : wreg
  task automatic rreg(input logic [7:0] i, input logic [7:0] e);
    host.xfer(1'b1, `VFM_IO_INDEX, i);
    expQ.push_back(e);
    host.xfer(1'b0, `VFM_IO_DATA, 8'h00);
  endtask : rreg
  task report_and_stop;
    $display("checks=%0d errors=%0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // An answer with nothing expected is a mismatch too
  always @(negedge mclk) begin
    if (ioRdValid === 1'b1) begin
      if (expQ.size() == 0) cmp(ioRdData, 32'h100);
      else cmp(ioRdData, expQ.pop_front());
    end
  end
  initial begin
    #(50 * 5000);
    failCount++;
    report_and_stop();
  end
  // ==========
  // Main sequence
  initial begin
    void'($urandom(32'h2621AC76));
    {alphaMode, attrByte, charCode, glyphRow, sysAddr, sysReq} = '0;
    repeat (16) @(negedge mclk);
    rst_b = 1'b1;
    rreg(`VFM_IDX_FONTSEL, 8'h00);
    rreg(`VFM_IDX_MEMMODE, 8'h00);
    rreg(`VFM_IDX_PLANEMASK, 8'h0F);
    rreg(`VFM_IDX_RESET, `VFM_RST_RESET);
    rreg(`VFM_IDX_CLOCKING, `VFM_RST_CLOCKING);
    wreg(`VFM_IDX_PLANEMASK, 8'h05);
    rreg(`VFM_IDX_PLANEMASK, 8'h05);
    wreg(`VFM_IDX_FONTSEL, 8'h3F);
    rreg(`VFM_IDX_FONTSEL, 8'h3F);
    wreg(`VFM_IDX_MEMMODE, 8'h0E);
    rreg(`VFM_IDX_MEMMODE, 8'h0E);
    wreg(8'h05, 8'hA5);
    rreg(8'h05, 8'h00);
    expQ.push_back(8'h05);
    host.xfer(1'b0, `VFM_IO_INDEX, 8'h00);
    host.xfer(1'b0, 16'h03C6, 8'h00);
    for (int i = 0; i < 16; i++) begin
      fs = 8'($urandom) & 8'h3F;
      wreg(`VFM_IDX_FONTSEL, fs);
      wreg(`VFM_IDX_MEMMODE, {6'h00, i[0], 1'b0});
      alphaMode = i[1];
      {attrByte, charCode, glyphRow} = 21'($urandom);
      repeat (2) @(negedge mclk);
      selA = {fs[5], fs[3], fs[2]};
      selB = {fs[4], fs[1], fs[0]};
      sel = (alphaMode && i[0] && selA != selB && !attrByte[3]) ? selB : selA;
      cmp(fontAddr, {sel[1:0], sel[2], charCode, glyphRow});
      cmp(dualFontActive, alphaMode && i[0] && selA != selB);
    end
    sysReq = 1'b1;
    for (int i = 0; i < 20; i++) begin
      fs = modes[i % 5];
      mask = 8'($urandom) & 8'h0F;
      a = 18'($urandom);
      wreg(`VFM_IDX_PLANEMASK, mask);
      wreg(`VFM_IDX_MEMMODE, fs);
      sysAddr = a;
      repeat (2) @(negedge mclk);
      pe = fs[3] ? 4'h1 << a[1:0] : fs[2] ? mask[3:0] : mask[3:0] & (a[0] ? 4'hA : 4'h5);
      if (!fs[1] && a[17:16] != 2'h0) pe = 4'h0;
      cmp(planeEnable, pe);
      cmp(sysHit, fs[1] || a[17:16] == 2'h0);
      cmp(planeAddr, fs[3] ? a >> 2 : a);
    end
    rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    cmp(planeEnable, 4'h0);
    rst_b = 1'b1;
    rreg(`VFM_IDX_FONTSEL, 8'h00);
    rreg(`VFM_IDX_MEMMODE, 8'h00);
    repeat (3) @(negedge mclk);
    cmp(expQ.size(), 0);
    report_and_stop();
  end
endmodule : tb_vfm_sequencer
`default_nettype wire
